//--- cssp_top.sv
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module cssp_top #(
  parameter int unsigned TICK_CYCLES = cssp_pkg::TICK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // command sources
  input wire logic link_enable_input_i,
  input wire logic [15:0] freq_setting_i,
  input wire logic multistep_active_i,
  input wire logic [15:0] multistep_freq_i,
  input wire logic keypad_run_i,
  input wire logic terminal_run_i,
  input wire logic [15:0] std_link_freq_i,
  input wire logic std_link_run_i,
  input wire logic [15:0] opt_link_freq_i,
  input wire logic opt_link_run_i,
  input wire logic [15:0] fbus_freq_i,
  input wire logic fbus_run_i,
  // protection and monitors
  input wire logic [9:0] thermistor_input_terminal_i,
  input wire logic forced_stop_input_i,
  input wire logic limiter_active_i,
  input wire logic [15:0] limited_freq_i,
  input wire logic fan_running_i,
  input wire logic [15:0] bus_cap_measured_i,
  input wire logic [15:0] bus_cap_initial_i,
  output logic [1:0] freq_source_o,
  output logic [1:0] run_source_o,
  output logic [15:0] freq_cmd_o,
  output logic run_cmd_o,
  output logic motor_alarm_o,
  output logic alarm_stop_o,
  output logic [1:0] alarm_code_o,
  output logic forced_decel_o,
  output logic [7:0] search_harmonize_time_o,
  output logic irq_o
);

  // =====================================================
  // state
  localparam int unsigned IRQ_W = cssp_pkg::IRQ_W;

  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [9:0] level;
    logic [15:0] decel;
    logic [15:0] lowlim;
    logic [7:0] search;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0] tick_cnt;
    logic [31:0] fan_time;
    logic [31:0] brd_time;
    logic [15:0] decel_cnt;
    cssp_pkg::cssp_src_t fsrc;
    cssp_pkg::cssp_src_t rsrc;
    cssp_pkg::cssp_state_t st;
    cssp_pkg::cssp_alarm_t alarm;
    logic over;
    logic warn;
    logic [15:0] freq;
    logic run;
  } cssp_regs_t;

  localparam cssp_regs_t RST = '{
    ctrl: cssp_pkg::CTRL_RST,
    level: cssp_pkg::LEVEL_RST,
    decel: cssp_pkg::DECEL_RST,
    lowlim: cssp_pkg::LOWLIM_RST,
    search: cssp_pkg::SEARCH_RST,
    fsrc: cssp_pkg::SRC_LOCAL,
    rsrc: cssp_pkg::SRC_LOCAL,
    st: cssp_pkg::ST_RUN,
    alarm: cssp_pkg::ALM_NONE,
    default: '0
  };

  cssp_regs_t r_reg;
  cssp_regs_t r_next;

  // =====================================================
  // decoders
  function automatic cssp_pkg::cssp_src_t freq_src_of(
    input logic [3:0] sel
  );
    unique case (sel)
      4'h1, 4'h3, 4'h7: freq_src_of = cssp_pkg::SRC_STD;
      4'h4, 4'h5, 4'h8: freq_src_of = cssp_pkg::SRC_OPT;
      default: freq_src_of = cssp_pkg::SRC_LOCAL;
    endcase
  endfunction

  function automatic cssp_pkg::cssp_src_t run_src_of(
    input logic [3:0] sel
  );
    unique case (sel)
      4'h2, 4'h3, 4'h5: run_src_of = cssp_pkg::SRC_STD;
      4'h6, 4'h7, 4'h8: run_src_of = cssp_pkg::SRC_OPT;
      default: run_src_of = cssp_pkg::SRC_LOCAL;
    endcase
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // =====================================================
  // combinational helpers
  logic [3:0] link_sel;
  logic [1:0] fb_sel;
  logic [1:0] thm_mode;
  logic gate_on;
  logic fstop_req;
  logic do_wr;
  logic tick;
  logic [31:0] wv;
  logic [15:0] sel_freq;
  logic sel_run;
  logic [15:0] run_freq;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic alarm_clr;
  cssp_pkg::cssp_src_t fsrc_n;
  cssp_pkg::cssp_src_t rsrc_n;

  assign link_sel = r_reg.ctrl[cssp_pkg::CTRL_LINK_LSB +: 4];
  assign fb_sel = r_reg.ctrl[cssp_pkg::CTRL_FB_LSB +: 2];
  assign thm_mode = r_reg.ctrl[cssp_pkg::CTRL_THM_LSB +: 2];
  // enable input gates only when assigned, else settings stand
  assign gate_on = !r_reg.ctrl[cssp_pkg::CTRL_LE_ASSIGNED]
    || link_enable_input_i;
  assign fstop_req = forced_stop_input_i
    && (r_reg.ctrl[cssp_pkg::CTRL_STOP_FN_LSB +: 8]
    == cssp_pkg::STOP_FUNC_CODE);
  assign do_wr = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
  assign tick = (r_reg.tick_cnt == TICK_CYCLES - 1);
  assign wv = merge(32'h0000_0000, r_reg.wdata, r_reg.wstrb);

  always_comb begin
    fsrc_n = cssp_pkg::SRC_LOCAL;
    rsrc_n = cssp_pkg::SRC_LOCAL;
    if (gate_on) begin
      fsrc_n = freq_src_of(link_sel);
      rsrc_n = run_src_of(link_sel);
      if (fb_sel[0]) begin
        fsrc_n = cssp_pkg::SRC_FBUS;
      end
      if (fb_sel[1]) begin
        rsrc_n = cssp_pkg::SRC_FBUS;
      end
    end
  end

  // only the selected source reaches the drive, except limited_freq_i while the limiter is active
  always_comb begin
    unique case (r_reg.fsrc)
      cssp_pkg::SRC_STD: sel_freq = std_link_freq_i;
      cssp_pkg::SRC_OPT: sel_freq = opt_link_freq_i;
      cssp_pkg::SRC_FBUS: sel_freq = fbus_freq_i;
      cssp_pkg::SRC_LOCAL: sel_freq = multistep_active_i
        ? multistep_freq_i : freq_setting_i;
    endcase
    unique case (r_reg.rsrc)
      cssp_pkg::SRC_STD: sel_run = std_link_run_i;
      cssp_pkg::SRC_OPT: sel_run = opt_link_run_i;
      cssp_pkg::SRC_FBUS: sel_run = fbus_run_i;
      cssp_pkg::SRC_LOCAL: sel_run = r_reg.ctrl[cssp_pkg::CTRL_RUN_TERM]
        ? terminal_run_i : keypad_run_i;
    endcase
  end

  // limiter output is floored at the low limit
  always_comb begin
    run_freq = sel_freq;
    if (limiter_active_i) begin
      run_freq = (limited_freq_i < r_reg.lowlim)
        ? r_reg.lowlim : limited_freq_i;
    end
  end

  // =====================================================
  // next state
  always_comb begin
    r_next = r_reg;
    irq_set = '0;
    irq_clr = '0;
    alarm_clr = 1'b0;

    // write channel
    if (s_axi_awvalid && s_axi_awready) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_next.w_got = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (do_wr) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = cssp_pkg::RESP_OKAY;
      unique case ({r_reg.awaddr[7:2], 2'b00})
        cssp_pkg::OFS_CTRL:
          r_next.ctrl = merge(r_reg.ctrl, r_reg.wdata, r_reg.wstrb);
        cssp_pkg::OFS_LEVEL:
          r_next.level = (wv[9:0] > cssp_pkg::LEVEL_MAX)
            ? cssp_pkg::LEVEL_MAX : wv[9:0];
        cssp_pkg::OFS_DECEL:
          r_next.decel = wv[15:0];
        cssp_pkg::OFS_LOWLIM:
          r_next.lowlim = (wv[15:0] > cssp_pkg::LOWLIM_MAX)
            ? cssp_pkg::LOWLIM_MAX : wv[15:0];
        cssp_pkg::OFS_SEARCH:
          r_next.search = (wv[7:0] > cssp_pkg::SEARCH_MAX)
            ? cssp_pkg::SEARCH_MAX : wv[7:0];
        cssp_pkg::OFS_IRQ_STS:
          irq_clr = wv[IRQ_W-1:0];
        cssp_pkg::OFS_IRQ_MASK:
          r_next.irq_mask = wv[IRQ_W-1:0];
        cssp_pkg::OFS_ALARM_CLR:
          alarm_clr = wv[0];
        cssp_pkg::OFS_STATUS, cssp_pkg::OFS_CAP_MEAS,
        cssp_pkg::OFS_CAP_INIT, cssp_pkg::OFS_FAN_TIME,
        cssp_pkg::OFS_BRD_TIME: ;
        default: r_next.bresp = cssp_pkg::RESP_SLVERR;
      endcase
    end

    // read channel
    if (s_axi_rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = cssp_pkg::RESP_OKAY;
      r_next.rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[7:2], 2'b00})
        cssp_pkg::OFS_CTRL: r_next.rdata = r_reg.ctrl;
        cssp_pkg::OFS_LEVEL: r_next.rdata[9:0] = r_reg.level;
        cssp_pkg::OFS_DECEL: r_next.rdata[15:0] = r_reg.decel;
        cssp_pkg::OFS_LOWLIM: r_next.rdata[15:0] = r_reg.lowlim;
        cssp_pkg::OFS_SEARCH: r_next.rdata[7:0] = r_reg.search;
        cssp_pkg::OFS_STATUS:
          r_next.rdata[11:0] = {r_reg.run, r_reg.warn, r_reg.over,
            r_reg.alarm, r_reg.st, r_reg.rsrc, r_reg.fsrc, 1'b0};
        cssp_pkg::OFS_IRQ_STS: r_next.rdata[IRQ_W-1:0] = r_reg.irq_sts;
        cssp_pkg::OFS_IRQ_MASK: r_next.rdata[IRQ_W-1:0] = r_reg.irq_mask;
        cssp_pkg::OFS_CAP_MEAS:
          r_next.rdata[15:0] = bus_cap_measured_i;
        cssp_pkg::OFS_CAP_INIT:
          r_next.rdata[15:0] = bus_cap_initial_i;
        cssp_pkg::OFS_FAN_TIME: r_next.rdata = r_reg.fan_time;
        cssp_pkg::OFS_BRD_TIME: r_next.rdata = r_reg.brd_time;
        cssp_pkg::OFS_ALARM_CLR: ;
        default: r_next.rresp = cssp_pkg::RESP_SLVERR;
      endcase
    end

    // millisecond tick and run time counters
    r_next.tick_cnt = tick ? 32'h0000_0000 : r_reg.tick_cnt + 32'h1;
    if (tick) begin
      r_next.brd_time = r_reg.brd_time + 32'h1;
      if (fan_running_i) begin
        r_next.fan_time = r_reg.fan_time + 32'h1;
      end
    end

    // source selection every cycle
    r_next.fsrc = fsrc_n;
    r_next.rsrc = rsrc_n;
    if (fsrc_n != r_reg.fsrc || rsrc_n != r_reg.rsrc) begin
      irq_set[cssp_pkg::IRQ_SRC_CHG] = 1'b1;
    end

    // thermistor compare
    r_next.over = (thermistor_input_terminal_i > r_reg.level);
    r_next.warn = r_reg.over && (thm_mode == 2'h2);
    if (r_next.warn && !r_reg.warn) begin
      irq_set[cssp_pkg::IRQ_THM_WARN] = 1'b1;
    end

    // drive sequencing
    unique case (r_reg.st)
      cssp_pkg::ST_RUN: begin
        r_next.freq = run_freq;
        r_next.run = sel_run;
        if (r_reg.over && thm_mode == 2'h1) begin
          r_next.st = cssp_pkg::ST_ALARM;
          r_next.alarm = cssp_pkg::ALM_THERM;
          r_next.freq = 16'h0000;
          r_next.run = 1'b0;
          irq_set[cssp_pkg::IRQ_THM_TRIP] = 1'b1;
        end else if (fstop_req) begin
          r_next.st = cssp_pkg::ST_DECEL;
          r_next.freq = r_reg.freq;
          r_next.decel_cnt = 16'h0000;
        end
      end
      cssp_pkg::ST_DECEL: begin
        if (r_reg.freq == 16'h0000) begin
          r_next.st = cssp_pkg::ST_ALARM;
          r_next.alarm = cssp_pkg::ALM_FSTOP;
          r_next.run = 1'b0;
          irq_set[cssp_pkg::IRQ_FSTOP] = 1'b1;
        end else if (tick) begin
          if (r_reg.decel_cnt + 16'h1 >= r_reg.decel) begin
            r_next.decel_cnt = 16'h0000;
            r_next.freq = r_reg.freq - 16'h1;
          end else begin
            r_next.decel_cnt = r_reg.decel_cnt + 16'h1;
          end
        end
      end
      cssp_pkg::ST_ALARM: begin
        r_next.freq = 16'h0000;
        r_next.run = 1'b0;
        if (alarm_clr) begin
          r_next.st = cssp_pkg::ST_RUN;
          r_next.alarm = cssp_pkg::ALM_NONE;
        end
      end
      default: begin
        r_next.st = cssp_pkg::ST_ALARM;
        r_next.freq = 16'h0000;
        r_next.run = 1'b0;
      end
    endcase

    // sticky status, set wins over clear
    r_next.irq_sts = (r_reg.irq_sts & ~irq_clr) | irq_set;
  end

  // =====================================================
  // registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // =====================================================
  // outputs
  assign s_axi_awready = !r_reg.aw_got && !r_reg.bvalid;
  assign s_axi_wready = !r_reg.w_got && !r_reg.bvalid;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign freq_source_o = r_reg.fsrc;
  assign run_source_o = r_reg.rsrc;
  assign freq_cmd_o = r_reg.freq;
  assign run_cmd_o = r_reg.run;
  assign motor_alarm_o = r_reg.warn;
  assign alarm_stop_o = (r_reg.st == cssp_pkg::ST_ALARM);
  assign alarm_code_o = r_reg.alarm;
  assign forced_decel_o = (r_reg.st == cssp_pkg::ST_DECEL);
  assign search_harmonize_time_o = r_reg.search;
  assign irq_o = |(r_reg.irq_sts & r_reg.irq_mask);

endmodule // cssp_top

//--- cssp_pkg.sv
package cssp_pkg;
  // =====================================================
  // timing
  localparam int unsigned CLK_NS = 5;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = (TICK_MS * 1000000) / CLK_NS;
  // =====================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_DECEL = 8'h08;
  localparam logic [7:0] OFS_LOWLIM = 8'h0C;
  localparam logic [7:0] OFS_SEARCH = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFS_CAP_MEAS = 8'h20;
  localparam logic [7:0] OFS_CAP_INIT = 8'h24;
  localparam logic [7:0] OFS_FAN_TIME = 8'h28;
  localparam logic [7:0] OFS_BRD_TIME = 8'h2C;
  localparam logic [7:0] OFS_ALARM_CLR = 8'h30;
  // =====================================================
  // control fields
  localparam int unsigned CTRL_LINK_LSB = 0;
  localparam int unsigned CTRL_FB_LSB = 4;
  localparam int unsigned CTRL_THM_LSB = 6;
  localparam int unsigned CTRL_LE_ASSIGNED = 8;
  localparam int unsigned CTRL_RUN_TERM = 9;
  localparam int unsigned CTRL_STOP_FN_LSB = 16;
  localparam logic [7:0] STOP_FUNC_CODE = 8'h1E;
  localparam logic [3:0] LINK_MAX = 4'h8;
  // =====================================================
  // limits and reset values
  localparam logic [9:0] LEVEL_MAX = 10'h1F4;
  localparam logic [15:0] LOWLIM_MAX = 16'h0258;
  localparam logic [7:0] SEARCH_MAX = 8'h64;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [9:0] LEVEL_RST = 10'h1F4;
  localparam logic [15:0] DECEL_RST = 16'h0001;
  localparam logic [15:0] LOWLIM_RST = 16'h0000;
  localparam logic [7:0] SEARCH_RST = 8'h00;
  // =====================================================
  // interrupt bits and bus response codes
  localparam int unsigned IRQ_THM_TRIP = 0;
  localparam int unsigned IRQ_THM_WARN = 1;
  localparam int unsigned IRQ_FSTOP = 2;
  localparam int unsigned IRQ_SRC_CHG = 3;
  localparam int unsigned IRQ_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // =====================================================
  // enumerations
  typedef enum logic [1:0] {
    SRC_LOCAL = 2'b00,
    SRC_STD = 2'b01,
    SRC_OPT = 2'b10,
    SRC_FBUS = 2'b11
  } cssp_src_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DECEL = 2'b01,
    ST_ALARM = 2'b10
  } cssp_state_t;
  typedef enum logic [1:0] {
    ALM_NONE = 2'b00,
    ALM_THERM = 2'b01,
    ALM_FSTOP = 2'b10
  } cssp_alarm_t;
endpackage

//--- cssp_props.sv
`timescale 1ns/10ps
// ==========================================================
// port checker
module cssp_props (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic limiter_active_i,
  input wire logic [15:0] limited_freq_i,
  input wire logic [15:0] freq_cmd_o,
  input wire logic alarm_stop_o,
  input wire logic [1:0] alarm_code_o,
  input wire logic forced_decel_o
);
  default clocking dc @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_wresp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wresp: assert property (p_wresp) else $error("write answer late");
  property p_rresp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");
  property p_bref;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_bref: assert property (p_bref) else $error("write taken during answer");
  property p_rref;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rref: assert property (p_rref) else $error("read taken during answer");
  property p_dec_mono;
    forced_decel_o && $past(forced_decel_o)
      |-> freq_cmd_o <= $past(freq_cmd_o);
  endproperty
  a_dec_mono: assert property (p_dec_mono) else $error("decel rises");
  property p_dec_end;
    $fell(forced_decel_o) |-> alarm_stop_o && freq_cmd_o == 16'h0000;
  endproperty
  a_dec_end: assert property (p_dec_end) else $error("decel end no alarm");
  property p_code;
    alarm_stop_o |-> alarm_code_o != 2'h0;
  endproperty
  a_code: assert property (p_code) else $error("alarm without code");
  property p_lowlim;
    $past(limiter_active_i) && !$past(forced_decel_o) && !$past(alarm_stop_o)
      && !forced_decel_o && !alarm_stop_o
      |-> freq_cmd_o >= $past(limited_freq_i);
  endproperty
  a_lowlim: assert property (p_lowlim) else $error("limit below limiter");
endmodule // cssp_props
bind cssp_top cssp_props u_props (.*);

//--- cssp_remote.sv
`timescale 1ns/10ps
// ==========================================================
// remote controllers on standard, option and field bus links
module cssp_remote (
  input wire logic [15:0] base_i,
  input wire logic [2:0] run_i,
  output logic [15:0] std_freq_o,
  output logic std_run_o,
  output logic [15:0] opt_freq_o,
  output logic opt_run_o,
  output logic [15:0] fb_freq_o,
  output logic fb_run_o
);
  // distinct values so the selected link can be told apart
  assign std_freq_o = base_i + 16'h0001;
  assign opt_freq_o = base_i + 16'h0002;
  assign fb_freq_o = base_i + 16'h0003;
  assign {fb_run_o, opt_run_o, std_run_o} = run_i;
endmodule // cssp_remote

//--- test_command_source_select_and_protection.sv
`timescale 1ns/10ps
module test_command_source_select_and_protection;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, freq_source_o, run_source_o;
  logic link_enable_input_i = 1'b0, multistep_active_i = 1'b0;
  logic keypad_run_i = 1'b1, terminal_run_i = 1'b0, forced_stop_input_i = 1'b0;
  logic limiter_active_i = 1'b0, fan_running_i = 1'b0;
  logic [15:0] freq_setting_i = 16'h0050, multistep_freq_i = 16'h0077;
  logic [15:0] limited_freq_i = 16'h0, base = 16'h0100;
  logic [15:0] bus_cap_measured_i = 16'h1234, bus_cap_initial_i = 16'h5678;
  logic [9:0] thermistor_input_terminal_i = 10'h000;
  logic [2:0] rrun = 3'b010;
  logic [15:0] std_link_freq_i, opt_link_freq_i, fbus_freq_i, freq_cmd_o;
  logic std_link_run_i, opt_link_run_i, fbus_run_i, run_cmd_o, irq_o;
  logic motor_alarm_o, alarm_stop_o, forced_decel_o;
  logic [1:0] alarm_code_o;
  logic [7:0] search_harmonize_time_o;
  int failures = 0, n_tests = 0;
  localparam logic [1:0] OK = cssp_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = cssp_pkg::RESP_SLVERR;

  cssp_top #(.TICK_CYCLES(4)) dut (.*);
  cssp_remote remote (.base_i(base), .run_i(rrun),
    .std_freq_o(std_link_freq_i), .std_run_o(std_link_run_i),
    .opt_freq_o(opt_link_freq_i), .opt_run_o(opt_link_run_i),
    .fb_freq_o(fbus_freq_i), .fb_run_o(fbus_run_i));

  always #2.5 sys_clk_i = ~sys_clk_i;

  // ========================================================
  // checks and bus tasks
  task automatic err(input string m);
    failures++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) err($sformatf("got %h expected %h", g, e));
  endtask
  task automatic settle();
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk(32'(s_axi_bresp), 32'(er));
        return;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        return;
      end
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask
  function automatic int fs(int l, int f);
    if (f[0]) return 3;
    if (l == 1 || l == 3 || l == 7) return 1;
    return (l == 4 || l == 5 || l == 8) ? 2 : 0;
  endfunction
  function automatic int rs(int l, int f);
    if (f[1]) return 3;
    return (l == 2 || l == 3 || l == 5) ? 1 : ((l >= 6) ? 2 : 0);
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err("watchdog expired");
    final_report();
  end

  // ========================================================
  // test sequence
  initial begin
    logic [31:0] d0, d1;
    logic [1:0] r;
    int n;
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rc(8'h00, cssp_pkg::CTRL_RST, OK);
    rc(8'h04, 32'(cssp_pkg::LEVEL_RST), OK);
    rc(8'h0C, 32'(cssp_pkg::LOWLIM_RST), OK);
    rc(8'h10, 32'(cssp_pkg::SEARCH_RST), OK);
    rc(8'h40, 32'h0, ERR);
    wr(8'h40, 32'h1, ERR);
    for (int l = 0; l < 9; l++) begin
      for (int f = 0; f < 4; f++) begin
        wr(8'h00, 32'(l + 16 * f), OK);
        settle();
        chk(32'(freq_source_o), fs(l, f));
        chk(32'(run_source_o), rs(l, f));
        chk(32'(freq_cmd_o), fs(l, f) ? 32'(base) + fs(l, f) : 32'h50);
        chk(32'(run_cmd_o), 32'(rs(l, f) == 0 || rs(l, f) == 2));
      end
    end
    wr(8'h00, 32'h0000_0103, OK);
    settle();
    chk(32'({freq_source_o, run_source_o}), 32'h0);
    link_enable_input_i <= 1'b1;
    settle();
    chk(32'({freq_source_o, run_source_o}), 32'h5);
    rc(8'h18, 32'h8, OK);
    wr(8'h00, 32'h0000_0200, OK);
    multistep_active_i <= 1'b1;
    settle();
    chk(32'({freq_cmd_o, run_cmd_o}), 32'h0EE);
    multistep_active_i <= 1'b0;
    terminal_run_i <= 1'b1;
    settle();
    chk(32'({freq_cmd_o, run_cmd_o}), 32'h0A1);
    // ========================================================
    // thermistor compare and interrupt path
    wr(8'h1C, 32'h0, OK);
    wr(8'h18, 32'hF, OK);
    wr(8'h04, 32'h3FF, OK);
    rc(8'h04, 32'h1F4, OK);
    wr(8'h04, 32'h64, OK);
    wr(8'h00, 32'h0000_0280, OK);
    thermistor_input_terminal_i <= 10'h064;
    settle();
    chk(32'(motor_alarm_o), 32'h0);
    thermistor_input_terminal_i <= 10'h065;
    settle();
    chk(32'({motor_alarm_o, alarm_stop_o, run_cmd_o, irq_o}), 32'hA);
    rc(8'h18, 32'h2, OK);
    wr(8'h1C, 32'h2, OK);
    settle();
    chk(32'(irq_o), 32'h1);
    wr(8'h18, 32'h2, OK);
    settle();
    chk(32'(irq_o), 32'h0);
    wr(8'h00, 32'h0000_0200, OK);
    settle();
    chk(32'({motor_alarm_o, alarm_stop_o}), 32'h0);
    wr(8'h00, 32'h0000_0240, OK);
    settle();
    chk(32'({motor_alarm_o, alarm_stop_o, alarm_code_o}), 32'h5);
    thermistor_input_terminal_i <= 10'h000;
    wr(8'h30, 32'h1, OK);
    settle();
    chk(32'(alarm_stop_o), 32'h0);
    // ========================================================
    // forced stop
    wr(8'h18, 32'hF, OK);
    wr(8'h1C, 32'h4, OK);
    wr(8'h00, 32'h001D_0000, OK);
    forced_stop_input_i <= 1'b1;
    settle();
    chk(32'(forced_decel_o), 32'h0);
    forced_stop_input_i <= 1'b0;
    wr(8'h00, 32'h001E_0000, OK);
    forced_stop_input_i <= 1'b1;
    settle();
    chk(32'(forced_decel_o), 32'h1);
    n = 0;
    while (alarm_stop_o !== 1'b1 && n < 1000) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk(32'(n >= 305 && n <= 330), 32'h1);
    chk(32'({alarm_code_o, freq_cmd_o, irq_o}), 32'h4_0001);
    rc(8'h18, 32'h4, OK);
    forced_stop_input_i <= 1'b0;
    wr(8'h18, 32'h4, OK);
    wr(8'h30, 32'h1, OK);
    settle();
    chk(32'({alarm_stop_o, irq_o}), 32'h0);
    // ========================================================
    // low limiter, search time, monitors
    wr(8'h00, 32'h0, OK);
    wr(8'h0C, 32'hFFFF, OK);
    rc(8'h0C, 32'h258, OK);
    wr(8'h0C, 32'h64, OK);
    limited_freq_i <= 16'h0032;
    limiter_active_i <= 1'b1;
    settle();
    chk(32'(freq_cmd_o), 32'h64);
    limited_freq_i <= 16'h0096;
    settle();
    chk(32'(freq_cmd_o), 32'h96);
    limiter_active_i <= 1'b0;
    wr(8'h10, 32'hFF, OK);
    settle();
    chk(32'(search_harmonize_time_o), 32'h64);
    wr(8'h10, 32'h32, OK);
    settle();
    chk(32'(search_harmonize_time_o), 32'h32);
    rc(8'h20, 32'h1234, OK);
    rc(8'h24, 32'h5678, OK);
    for (int a = 0; a < 3; a++) begin
      fan_running_i <= (a == 0);
      rd((a == 2) ? 8'h2C : 8'h28, d0, r);
      repeat (40) @(posedge sys_clk_i);
      rd((a == 2) ? 8'h2C : 8'h28, d1, r);
      chk(32'((d1 - d0) >= 9 && (d1 - d0) <= 13), 32'(a != 1));
    end
    final_report();
  end
endmodule // test_command_source_select_and_protection
